// *** design/sfv_regfile.v ***
// shared fp scalar and simd vector register file with flush-to-zero
`timescale 1ns/10ps
`include "sfv_defines.vh"
module sfv_regfile
(
    input wire clk_sys,
    input wire reset_n,
    input wire flush_subnormal_enable,
    input wire simd_rd_en,
    input wire [`SFV_AW-1:0] simd_rd_reg,
    input wire [2:0] simd_rd_fmt,
    input wire [3:0] simd_rd_idx,
    output reg [`SFV_VW-1:0] simd_rd_vec_r,
    output reg [`SFV_DW-1:0] simd_rd_elem_r,
    output reg simd_rd_valid_r,
    input wire simd_wr_en,
    input wire [`SFV_AW-1:0] simd_wr_reg,
    input wire [`SFV_VW-1:0] simd_wr_data,
    input wire sc_rd_en,
    input wire [`SFV_AW-1:0] sc_rd_reg,
    input wire [1:0] sc_rd_kind,
    input wire sc_rd_cmp,
    output reg [`SFV_DW-1:0] sc_rd_data_r,
    output reg sc_rd_inexact_r,
    output reg sc_rd_valid_r,
    input wire sc_wr_en,
    input wire [`SFV_AW-1:0] sc_wr_reg,
    input wire [1:0] sc_wr_kind,
    input wire [`SFV_DW-1:0] sc_wr_data,
    input wire sc_wr_is_fp,
    input wire sc_wr_recip,
    input wire [15:0] sc_wr_unr_exp,
    output reg sc_wr_inexact_r,
    output reg sc_wr_underflow_r,
    output reg sc_wr_done_r
);
    // ****************************************
    // element helpers
    // ****************************************
    function [`SFV_DW-1:0] pick_elem;
        input [`SFV_VW-1:0] v;
        input [2:0] fmt;
        input [3:0] idx;
        begin
            case (fmt)
                `SFV_FMT_B: pick_elem = {56'h0, v[idx*8 +: 8]};
                `SFV_FMT_H: pick_elem = {48'h0, v[idx[2:0]*16 +: 16]};
                `SFV_FMT_W: pick_elem = {32'h0, v[idx[1:0]*32 +: 32]};
                `SFV_FMT_D: pick_elem = v[idx[0]*64 +: 64];
                default: pick_elem = v[`SFV_DW-1:0];
            endcase
        end
    endfunction

    // ****************************************
    // storage port selection
    // ****************************************
    reg [`SFV_AW-1:0] rd_addr;
    reg wr_en;
    reg [`SFV_AW-1:0] wr_addr;
    reg [`SFV_VW/8-1:0] wr_be;
    reg [`SFV_VW-1:0] wr_data;
    wire [`SFV_VW-1:0] rd_data;
    wire [`SFV_DW-1:0] wr_flushed_val;
    wire wr_flushed;
    reg tiny;
    reg wr_zero;

    sfv_flush u_res_flush
    (
        .val(sc_wr_data),
        .is_dp(sc_wr_kind == `SFV_SC_D),
        .is_result(1'b0),
        .enable(flush_subnormal_enable && sc_wr_is_fp),
        .out(wr_flushed_val),
        .flushed(wr_flushed)
    );

    always @*
    begin
        // tininess from the unrounded exponent, rounding comes later
        if (sc_wr_kind == `SFV_SC_D)
        begin
            tiny = $signed(sc_wr_unr_exp) < $signed(`SFV_DP_EMIN);
            wr_zero = sc_wr_data[`SFV_DP_EXP_MSB:0] == 63'h0;
        end
        else
        begin
            tiny = $signed(sc_wr_unr_exp) < $signed(`SFV_SP_EMIN);
            wr_zero = sc_wr_data[`SFV_SP_EXP_MSB:0] == 31'h0;
        end
    end

    wire res_flush = flush_subnormal_enable && sc_wr_is_fp &&
        (tiny || wr_flushed) && !wr_zero;
    reg [`SFV_DW-1:0] res_val;
    always @*
    begin
        res_val = sc_wr_data;
        if (res_flush)
        begin
            if (sc_wr_kind == `SFV_SC_D)
            begin
                res_val = {sc_wr_data[`SFV_DP_SIGN], 63'h0};
            end
            else
            begin
                res_val = {32'h0, sc_wr_data[`SFV_SP_SIGN], 31'h0};
            end
        end
        else if (wr_flushed)
        begin
            res_val = wr_flushed_val;
        end
    end

    always @*
    begin
        rd_addr = sc_rd_en ? sc_rd_reg : simd_rd_reg;
        wr_en = 1'b0;
        wr_addr = simd_wr_reg;
        wr_be = {`SFV_VW/8{1'b0}};
        wr_data = simd_wr_data;
        // simd write takes the port when both collide
        if (simd_wr_en)
        begin
            wr_en = 1'b1;
            wr_be = {`SFV_VW/8{1'b1}};
        end
        else if (sc_wr_en)
        begin
            wr_en = 1'b1;
            wr_addr = sc_wr_reg;
            // untouched lanes keep old data
            case (sc_wr_kind)
                `SFV_SC_D:
                begin
                    wr_be = 16'h00FF;
                    wr_data = {64'h0, res_val};
                end
                `SFV_SC_HI:
                begin
                    wr_be = 16'h00F0;
                    wr_data = {64'h0, sc_wr_data[`SFV_WW-1:0], 32'h0};
                end
                default:
                begin
                    wr_be = 16'h000F;
                    wr_data = {96'h0, res_val[`SFV_WW-1:0]};
                end
            endcase
        end
    end

    sfv_vec_mem u_mem
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .rd_addr(rd_addr),
        .rd_data_r(rd_data),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_be(wr_be),
        .wr_data(wr_data)
    );

    // ****************************************
    // read pipeline stage
    // ****************************************
    reg sc_pend_r;
    reg simd_pend_r;
    reg [1:0] sc_kind_r;
    reg sc_cmp_r;
    reg [2:0] simd_fmt_r;
    reg [3:0] simd_idx_r;
    reg [`SFV_DW-1:0] sc_raw;
    wire [`SFV_DW-1:0] op_val;
    wire op_flushed;

    always @*
    begin
        case (sc_kind_r)
            `SFV_SC_D: sc_raw = rd_data[`SFV_DW-1:0];
            `SFV_SC_HI: sc_raw = {32'h0, rd_data[63:32]};
            default: sc_raw = {32'h0, rd_data[`SFV_WW-1:0]};
        endcase
    end

    sfv_flush u_op_flush
    (
        .val(sc_raw),
        .is_dp(sc_kind_r == `SFV_SC_D),
        .is_result(1'b0),
        .enable(flush_subnormal_enable),
        .out(op_val),
        .flushed(op_flushed)
    );

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sc_pend_r <= 1'b0;
            simd_pend_r <= 1'b0;
            sc_kind_r <= `SFV_SC_W;
            sc_cmp_r <= 1'b0;
            simd_fmt_r <= `SFV_FMT_V;
            simd_idx_r <= 4'h0;
            sc_rd_data_r <= {`SFV_DW{1'b0}};
            sc_rd_inexact_r <= 1'b0;
            sc_rd_valid_r <= 1'b0;
            simd_rd_vec_r <= {`SFV_VW{1'b0}};
            simd_rd_elem_r <= {`SFV_DW{1'b0}};
            simd_rd_valid_r <= 1'b0;
            sc_wr_inexact_r <= 1'b0;
            sc_wr_underflow_r <= 1'b0;
            sc_wr_done_r <= 1'b0;
        end
        else
        begin
            // scalar read has priority on the shared read port
            sc_pend_r <= sc_rd_en;
            simd_pend_r <= simd_rd_en && !sc_rd_en;
            sc_kind_r <= sc_rd_kind;
            sc_cmp_r <= sc_rd_cmp;
            simd_fmt_r <= simd_rd_fmt;
            simd_idx_r <= simd_rd_idx;
            sc_rd_valid_r <= sc_pend_r;
            simd_rd_valid_r <= simd_pend_r;
            if (sc_pend_r)
            begin
                sc_rd_data_r <= op_val;
                sc_rd_inexact_r <= op_flushed && !sc_cmp_r;
            end
            else
            begin
                sc_rd_inexact_r <= 1'b0;
            end
            if (simd_pend_r)
            begin
                simd_rd_vec_r <= rd_data;
                simd_rd_elem_r <= pick_elem(rd_data, simd_fmt_r, simd_idx_r);
            end
            sc_wr_done_r <= sc_wr_en && !simd_wr_en;
            // approximate reciprocals are exempt from the flags
            sc_wr_inexact_r <= sc_wr_en && !simd_wr_en && res_flush &&
                !sc_wr_recip;
            sc_wr_underflow_r <= sc_wr_en && !simd_wr_en && res_flush &&
                !sc_wr_recip;
        end
    end
endmodule // sfv_regfile

// *** design/sfv_defines.vh ***
// shared constants for the fp and simd vector register file
`ifndef SFV_DEFINES_VH
`define SFV_DEFINES_VH
`define SFV_NREGS 32
`define SFV_AW 5
`define SFV_VW 128
`define SFV_DW 64
`define SFV_WW 32
`define SFV_FMT_B 3'h0
`define SFV_FMT_H 3'h1
`define SFV_FMT_W 3'h2
`define SFV_FMT_D 3'h3
`define SFV_FMT_V 3'h4
`define SFV_SC_W 2'h0
`define SFV_SC_D 2'h1
`define SFV_SC_HI 2'h2
`define SFV_SP_EXP_MSB 30
`define SFV_SP_EXP_LSB 23
`define SFV_SP_MAN_MSB 22
`define SFV_SP_SIGN 31
`define SFV_DP_EXP_MSB 62
`define SFV_DP_EXP_LSB 52
`define SFV_DP_MAN_MSB 51
`define SFV_DP_SIGN 63
`define SFV_SP_EMIN 16'h0001
`define SFV_DP_EMIN 16'h0001
`endif

// *** design/sfv_vec_mem.v ***
// thirty-two entry 128-bit storage with byte write enables
`timescale 1ns/10ps
`include "sfv_defines.vh"
module sfv_vec_mem
(
    input wire clk_sys,
    input wire reset_n,
    input wire [`SFV_AW-1:0] rd_addr,
    output reg [`SFV_VW-1:0] rd_data_r,
    input wire wr_en,
    input wire [`SFV_AW-1:0] wr_addr,
    input wire [`SFV_VW/8-1:0] wr_be,
    input wire [`SFV_VW-1:0] wr_data
);
    reg [`SFV_VW-1:0] mem [0:`SFV_NREGS-1];
    integer i;
    // no reset on the array itself, only on the read register
    always @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            for (i = 0; i < `SFV_VW/8; i = i + 1)
            begin
                if (wr_be[i])
                begin
                    mem[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
                end
            end
        end
    end
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data_r <= {`SFV_VW{1'b0}};
        end
        else
        begin
            rd_data_r <= mem[rd_addr];
        end
    end
endmodule // sfv_vec_mem

// *** design/sfv_flush.v ***
// flush-to-zero screen for one operand word, a result word (is_result) passes through unflushed
`timescale 1ns/10ps
`include "sfv_defines.vh"
module sfv_flush
(
    input wire [`SFV_DW-1:0] val,
    input wire is_dp,
    input wire is_result,
    input wire enable,
    output reg [`SFV_DW-1:0] out,
    output reg flushed
);
    reg sub;
    always @*
    begin
        sub = 1'b0;
        out = val;
        flushed = 1'b0;
        if (is_dp)
        begin
            sub = (val[`SFV_DP_EXP_MSB:`SFV_DP_EXP_LSB] == 11'h000) &&
                  (val[`SFV_DP_MAN_MSB:0] != 52'h0);
        end
        else
        begin
            sub = (val[`SFV_SP_EXP_MSB:`SFV_SP_EXP_LSB] == 8'h00) &&
                  (val[`SFV_SP_MAN_MSB:0] != 23'h0);
        end
        if (enable && sub && !is_result)
        begin
            flushed = 1'b1;
            if (is_dp)
            begin
                out = {val[`SFV_DP_SIGN], 63'h0};
            end
            else
            begin
                out = {32'h0, val[`SFV_SP_SIGN], 31'h0};
            end
        end
    end
endmodule // sfv_flush

// *** testbench/sfv_regfile_assertions.sv ***
// port assertions for the shared fp and simd register file
`timescale 1ns/10ps
module sfv_regfile_assertions
(
    input wire clk_sys, reset_n, flush_subnormal_enable, simd_rd_en, sc_rd_en,
    input wire sc_rd_cmp, sc_rd_valid_r, sc_rd_inexact_r, simd_rd_valid_r,
    input wire sc_wr_en, simd_wr_en, sc_wr_is_fp, sc_wr_recip, sc_wr_done_r,
    input wire sc_wr_inexact_r, sc_wr_underflow_r,
    input wire [1:0] sc_wr_kind,
    input wire [63:0] sc_wr_data,
    input wire [15:0] sc_wr_unr_exp
);
    // ********
    // checks
    // ********
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // only double kind screened here, word kinds are not checked by the bench either
    wire dp_tiny = sc_wr_en && !simd_wr_en && flush_subnormal_enable
        && sc_wr_is_fp && !sc_wr_recip && sc_wr_kind == 2'h1
        && $signed(sc_wr_unr_exp) < 16'sh0001 && sc_wr_data[62:0] != 63'h0;
    wire uf_ok = flush_subnormal_enable && sc_wr_is_fp && !sc_wr_recip;
    AST_SC_RD_LAT: assert property (sc_rd_en |-> ##2 sc_rd_valid_r)
        else $error("scalar read valid missing");
    AST_SIMD_LAT: assert property (simd_rd_en && !sc_rd_en |-> ##2
        simd_rd_valid_r) else $error("simd read valid missing");
    AST_SIMD_DROP: assert property (simd_rd_en && sc_rd_en |-> ##2
        !simd_rd_valid_r) else $error("colliding simd read answered");
    AST_WR_DONE: assert property (sc_wr_en && !simd_wr_en |=>
        sc_wr_done_r) else $error("scalar write done missing");
    AST_WR_DROP: assert property (sc_wr_en && simd_wr_en |=>
        !sc_wr_done_r) else $error("colliding scalar write done");
    AST_DP_TINY: assert property (dp_tiny |=>
        sc_wr_underflow_r && sc_wr_inexact_r) else $error("tiny not flagged");
    AST_UF_CAUSE: assert property (sc_wr_underflow_r |-> $past(uf_ok))
        else $error("underflow without cause");
    AST_UF_INX: assert property (sc_wr_underflow_r |-> sc_wr_inexact_r)
        else $error("underflow without inexact");
    AST_CMP_QUIET: assert property (sc_rd_valid_r && $past(sc_rd_cmp, 2)
        |-> !sc_rd_inexact_r) else $error("compare raised inexact");
    AST_INX_FTZ: assert property (sc_rd_inexact_r |-> sc_rd_valid_r &&
        $past(flush_subnormal_enable)) else $error("inexact without flush");
    cover property (dp_tiny);
    cover property (sc_rd_valid_r && sc_rd_inexact_r);
    cover property (simd_rd_en && sc_rd_en);
endmodule // sfv_regfile_assertions

// *** testbench/sfv_pipe.sv ***
// execution pipeline model issuing register file requests
`timescale 1ns/10ps
module sfv_pipe
(
    input wire clk_sys,
    output logic flush_subnormal_enable, simd_rd_en, sc_rd_en, sc_rd_cmp,
    output logic simd_wr_en, sc_wr_en, sc_wr_is_fp, sc_wr_recip,
    output logic [4:0] simd_rd_reg, simd_wr_reg, sc_rd_reg, sc_wr_reg,
    output logic [2:0] simd_rd_fmt,
    output logic [3:0] simd_rd_idx,
    output logic [1:0] sc_rd_kind, sc_wr_kind,
    output logic [127:0] simd_wr_data,
    output logic [63:0] sc_wr_data,
    output logic [15:0] sc_wr_unr_exp
);
    // ********
    // request tasks, one-cycle strobes
    // ********
    initial
    begin
        {flush_subnormal_enable, simd_rd_en, sc_rd_en, sc_rd_cmp} = 4'h0;
        {simd_wr_en, sc_wr_en, sc_wr_is_fp, sc_wr_recip} = 4'h0;
        {simd_rd_reg, simd_wr_reg, sc_rd_reg, sc_wr_reg} = 20'h00000;
        {simd_rd_fmt, simd_rd_idx, sc_rd_kind, sc_wr_kind} = 11'h000;
        {simd_wr_data, sc_wr_data, sc_wr_unr_exp} = 208'h0;
    end
    task automatic simd_wr(input [4:0] r, input [127:0] dd);
        @(posedge clk_sys);
        {simd_wr_en, simd_wr_reg, simd_wr_data} <= {1'b1, r, dd};
        @(posedge clk_sys);
        // stale data inverted so a late sample is caught
        {simd_wr_en, simd_wr_data} <= {1'b0, ~dd};
        #1;
    endtask
    task automatic sc_wr(input [4:0] r, input [1:0] k, input [63:0] dd,
        input fp, input rc, input [15:0] ue);
        @(posedge clk_sys);
        {sc_wr_en, sc_wr_reg, sc_wr_kind, sc_wr_data} <= {1'b1, r, k, dd};
        {sc_wr_is_fp, sc_wr_recip, sc_wr_unr_exp} <= {fp, rc, ue};
        @(posedge clk_sys);
        // done and flags stand one cycle, so hand back right after it
        {sc_wr_en, sc_wr_data} <= {1'b0, ~dd};
        #1;
    endtask
    task automatic sc_rd(input [4:0] r, input [1:0] k, input c);
        @(posedge clk_sys);
        {sc_rd_en, sc_rd_reg, sc_rd_kind, sc_rd_cmp} <= {1'b1, r, k, c};
        @(posedge clk_sys);
        sc_rd_en <= 1'b0;
        // valid pulse stands only for this one cycle
        @(posedge clk_sys);
        #1;
    endtask
    task automatic simd_rd(input [4:0] r, input [2:0] f, input [3:0] i);
        @(posedge clk_sys);
        {simd_rd_en, simd_rd_reg, simd_rd_fmt, simd_rd_idx} <= {1'b1, r, f, i};
        @(posedge clk_sys);
        simd_rd_en <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
endmodule // sfv_pipe

// *** testbench/sfv_regfile_tb.sv ***
// self-checking bench for the shared fp and simd register file
`timescale 1ns/10ps
module sfv_regfile_tb;
    logic clk_sys, reset_n, flush_subnormal_enable, simd_rd_en, sc_rd_en;
    logic sc_rd_cmp, simd_wr_en, sc_wr_en, sc_wr_is_fp, sc_wr_recip;
    logic [4:0] simd_rd_reg, simd_wr_reg, sc_rd_reg, sc_wr_reg, r;
    logic [2:0] simd_rd_fmt, f;
    logic [3:0] simd_rd_idx, ix;
    logic [1:0] sc_rd_kind, sc_wr_kind, kd;
    logic [127:0] simd_wr_data, simd_rd_vec_r, sh [32], d;
    logic [63:0] simd_rd_elem_r, sc_rd_data_r, sc_wr_data, v;
    logic [64:0] e;
    logic [15:0] sc_wr_unr_exp, x16;
    logic simd_rd_valid_r, sc_rd_inexact_r, sc_rd_valid_r, sc_wr_inexact_r;
    logic sc_wr_underflow_r, sc_wr_done_r, t;
    int n_errors, checked, s;
    sfv_regfile sfv_regfile_i (.*);
    sfv_pipe sfv_pipe_i (.*);
    always #5 clk_sys = ~clk_sys;
    // ********
    // expectation helpers
    // ********
    function automatic [127:0] el(input [127:0] q, input [2:0] g, input [3:0] i);
        case (g)
            3'h0: el = q[i * 8 +: 8];
            3'h1: el = q[i[2:0] * 16 +: 16];
            3'h2: el = q[i[1:0] * 32 +: 32];
            3'h3: el = q[i[0] * 64 +: 64];
            default: el = q;
        endcase
    endfunction
    function automatic [64:0] fz(input [63:0] q, input dp);
        if (dp)
            fz = (q[62:52] == 11'h0 && q[51:0] != 52'h0) ? {1'b1, q[63], 63'h0} : q;
        else
            fz = (q[30:23] == 8'h0 && q[22:0] != 23'h0) ?
                {1'b1, q[63:32], q[31], 31'h0} : q;
    endfunction
    function automatic [63:0] sx(input [127:0] q, input [1:0] k);
        sx = k == 2'h1 ? q[63:0] : {32'h0, k == 2'h2 ? q[63:32] : q[31:0]};
    endfunction
    function automatic [127:0] wsh(input [127:0] q, input [1:0] k,
        input [63:0] w);
        // unwritten bytes keep old contents
        wsh = q;
        if (k == 2'h1) wsh[63:0] = w;
        else if (k == 2'h2) wsh[63:32] = w[31:0];
        else wsh[31:0] = w[31:0];
    endfunction
    task automatic chk(input logic [127:0] g, input logic [127:0] x);
        checked++;
        if (g !== x)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, g, x);
        end
    endtask
    task automatic rs(input [4:0] q, input [1:0] k, input c, input [63:0] x,
        input n);
        sfv_pipe_i.sc_rd(q, k, c);
        chk(sc_rd_valid_r, 1'b1);
        chk(k == 2'h1 ? sc_rd_data_r : sc_rd_data_r[31:0], x);
        chk(sc_rd_inexact_r, n);
    endtask
    task automatic close_out;
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ********
    // scenarios
    // ********
    initial
    begin
        #100000;
        n_errors++;
        close_out;
    end
    initial
    begin
        {clk_sys, reset_n, n_errors, checked} = 0;
        s = $urandom(77);
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int k = 0; k < 64; k++)
        begin
            d = {$urandom, $urandom, $urandom, $urandom};
            {f, ix} = {3'(k % 5), 4'($urandom)};
            sfv_pipe_i.simd_wr(k[4:0], d);
            sfv_pipe_i.simd_rd(k[4:0], f, ix);
            sh[k[4:0]] = d;
            chk(simd_rd_valid_r, 1'b1);
            chk(f == 3'h4 ? simd_rd_vec_r : simd_rd_elem_r, el(d, f, ix));
        end
        for (int k = 0; k < 12; k++)
        begin
            {r, v, kd} = {5'($urandom), $urandom, $urandom, 2'(k % 3)};
            sfv_pipe_i.sc_wr(r, kd, v, 1'b0, 1'b0, 16'h0001);
            chk(sc_wr_done_r, 1'b1);
            sh[r] = wsh(sh[r], kd, v);
            sfv_pipe_i.simd_rd(r, 3'h4, 4'h0);
            chk(simd_rd_vec_r, sh[r]);
            kd = 2'((k + 1) % 3);
            rs(r, kd, 1'b0, sx(sh[r], kd), 1'b0);
        end
        sfv_pipe_i.flush_subnormal_enable <= 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            v = {$urandom, $urandom};
            if (k[0]) v[62:52] = 11'h000;
            if (k[1]) v[30:23] = 8'h00;
            sfv_pipe_i.simd_wr(5'h05, {64'h0, v});
            {e, kd} = {fz(v, k[0]), 1'b0, k[0]};
            rs(5'h05, kd, k[2], sx(e[63:0], kd), e[64] & !k[2]);
        end
        for (int k = 0; k < 8; k++)
        begin
            v = {$urandom, $urandom};
            // exponent looks normal, the unrounded one is tiny when k[1] or k[2] is set
            v[62:52] = 11'h001;
            x16 = k[1] ? 16'h0000 : (k[2] ? 16'hFFF0 : 16'h0001);
            t = k[1] | k[2];
            sfv_pipe_i.sc_wr(5'h07, 2'h1, v, 1'b1, k[0], x16);
            chk({sc_wr_underflow_r, sc_wr_inexact_r}, {2{t & !k[0]}});
            rs(5'h07, 2'h1, 1'b0, t ? {v[63], 63'h0} : v, 1'b0);
        end
        d = {$urandom, $urandom, $urandom, $urandom};
        fork
            sfv_pipe_i.simd_wr(5'h09, d);
            sfv_pipe_i.sc_wr(5'h09, 2'h1, 64'h0, 1'b0, 1'b0, 16'h0001);
        join
        chk(sc_wr_done_r, 1'b0);
        fork
            sfv_pipe_i.sc_rd(5'h09, 2'h1, 1'b0);
            sfv_pipe_i.simd_rd(5'h09, 3'h4, 4'h0);
        join
        e = fz(d[63:0], 1'b1);
        chk({simd_rd_valid_r, sc_rd_data_r}, {1'b0, e[63:0]});
        close_out;
    end
endmodule // sfv_regfile_tb
bind sfv_regfile sfv_regfile_assertions sfv_regfile_assertions_i (.*);
